// [dv/cc_axis_pulses.sv]
// partner model: master-axis and capture-axis pulse strobes
// assumes strobes are sampled on the rising edge of clk
`default_nettype none

module cc_axis_pulses (
    // clock
    input wire logic clk,
    // master pace in cycles, zero stops the stream
    input wire logic [7:0] master_period,
    // pulse strobes, idle low between pulses
    output logic master_pulse,
    output logic cap_pulse
);
    timeunit 1ns;
    timeprecision 1ps;

    int pace_cnt = 0;

    initial begin
        master_pulse = 1'b0;
        cap_pulse = 1'b0;
    end

    // a period that divides the rate window gives the same count in every window,
    // so the measured rate does not depend on where the window starts
    always @(negedge clk) begin
        if (master_period == 8'h00) begin
            master_pulse <= 1'b0;
            pace_cnt <= 0;
        end else if (pace_cnt >= int'(master_period) - 1) begin
            master_pulse <= 1'b1;
            pace_cnt <= 0;
        end else begin
            master_pulse <= 1'b0;
            pace_cnt <= pace_cnt + 1;
        end
    end

    // isolated capture-axis pulses, one low cycle after each
    task automatic send_cap(input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge clk);
            cap_pulse = 1'b1;
            @(negedge clk);
            cap_pulse = 1'b0;
        end
    endtask
endmodule

`default_nettype wire

// [dv/cc_comp_bench.sv]
// testbench for the capture/compare compensation block
// assumes a short rate window; inputs change on the falling clock edge
`default_nettype none

module cc_comp_bench;
    import cc_comp_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int WIN = 50;
    logic CLK = 1'b0;
    logic RST = 1'b1;
    logic PAR_WR = 1'b0, PAR_RD = 1'b0, TRACK_ENABLE = 1'b0, CAM_RUN = 1'b0;
    logic CAP_EVENT = 1'b0, CAP_LAST = 1'b0, CMP_DONE = 1'b0;
    logic [15:0] PAR_ADDR = 16'h0000, MOTOR_SPEED = 16'h0000, CAPTURE_ARRAY_START = 16'h0000;
    logic [31:0] PAR_WDATA = 32'h0000_0000;
    logic [7:0] master_period = 8'h00;
    logic [31:0] PAR_RDATA, TRACK_DIST, CAM_PHASE, CMP_OFFSET;
    logic [15:0] MASTER_RATE, CAP_ARRAY_BASE;
    logic PAR_RVALID, MASTER_PULSE, CAP_PULSE, CAP_ACCEPT, CAP_MASKED, CAP_RESTART;
    int err_count = 0;
    int check_count = 0;
    // cam cases: time, minimum rate, run, expected phase at 10 pulses per window
    logic [15:0] cam_time [8] = '{16'd2, 16'd2, 16'd2, 16'd2, 16'd2, 16'd0, 16'hfffe, 16'd2};
    logic [15:0] cam_min [8] = '{16'd3, 16'd9, 16'd10, 16'd12, 16'hfffe, 16'd3, 16'd3, 16'd3};
    logic cam_run [8] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
    logic [31:0] cam_exp [8] = '{32'd14, 32'd2, 32'd0, 32'd0, 32'd24, 32'd0, 32'd0, 32'd0};

    always #10 CLK = ~CLK;

    cc_comp #(.RATE_WINDOW(WIN)) dut_u (
        .CLK(CLK), .RST(RST), .PAR_WR(PAR_WR), .PAR_RD(PAR_RD), .PAR_ADDR(PAR_ADDR),
        .PAR_WDATA(PAR_WDATA), .PAR_RDATA(PAR_RDATA), .PAR_RVALID(PAR_RVALID),
        .TRACK_ENABLE(TRACK_ENABLE), .MOTOR_SPEED(MOTOR_SPEED), .TRACK_DIST(TRACK_DIST),
        .CAM_RUN(CAM_RUN), .MASTER_PULSE(MASTER_PULSE), .MASTER_RATE(MASTER_RATE),
        .CAM_PHASE(CAM_PHASE), .CAP_EVENT(CAP_EVENT), .CAP_PULSE(CAP_PULSE), .CAP_LAST(CAP_LAST),
        .CAPTURE_ARRAY_START(CAPTURE_ARRAY_START), .CAP_ACCEPT(CAP_ACCEPT), .CAP_MASKED(CAP_MASKED),
        .CAP_RESTART(CAP_RESTART), .CAP_ARRAY_BASE(CAP_ARRAY_BASE), .CMP_DONE(CMP_DONE),
        .CMP_OFFSET(CMP_OFFSET));

    cc_axis_pulses axis_u (.clk(CLK), .master_period(master_period), .master_pulse(MASTER_PULSE),
        .cap_pulse(CAP_PULSE));

    // ----------------------------------------
    // checks and access tasks
    // ----------------------------------------
    task automatic wrap_up();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check32(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic check1(input logic got, input logic exp, input string what);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge CLK);
    endtask

    // one write, then an idle cycle so back-to-back calls never re-raise the strobe at once
    task automatic par_write(input logic [15:0] a, input logic [31:0] d);
        PAR_WR = 1'b1;
        PAR_ADDR = a;
        PAR_WDATA = d;
        @(negedge CLK);
        PAR_WR = 1'b0;
        @(negedge CLK);
    endtask

    task automatic reg_check(input logic [15:0] a, input logic [31:0] exp);
        logic [31:0] d;
        d = 32'hxxxx_xxxx;
        PAR_RD = 1'b1;
        PAR_ADDR = a;
        @(negedge CLK);
        PAR_RD = 1'b0;
        for (int n = 0; n < 3; n++) begin
            if (PAR_RVALID === 1'b1) begin
                d = PAR_RDATA;
                break;
            end
            @(negedge CLK);
        end
        check32(d, exp, "register read");
        @(negedge CLK);
    endtask

    // event held one or two cycles; the second cycle lands right after the first answer
    task automatic capture(input logic acc, input logic msk, input string what);
        CAP_EVENT = 1'b1;
        @(negedge CLK);
        CAP_EVENT = 1'b0;
        check1(CAP_ACCEPT, acc, what);
        check1(CAP_MASKED, msk, what);
        @(negedge CLK);
    endtask

    task automatic strobe_last(input logic exp);
        CAP_LAST = 1'b1;
        @(negedge CLK);
        CAP_LAST = 1'b0;
        check1(CAP_RESTART, exp, "restart after last point");
        @(negedge CLK);
    endtask

    task automatic compare_once(input logic [31:0] exp);
        CMP_DONE = 1'b1;
        @(negedge CLK);
        CMP_DONE = 1'b0;
        @(negedge CLK);
        check32(CMP_OFFSET, exp, "offset after compare");
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        repeat (6) @(negedge CLK);
        RST = 1'b0;
        @(negedge CLK);
        reg_check(ADDR_CAM_PHASE_TIME, 32'h0000_0000);
        reg_check(ADDR_CC_OPTIONS, 32'h0000_0000);
        reg_check(ADDR_CAPTURE_MASK, 32'h0000_0000);
        reg_check(ADDR_CAM_MIN_RATE, 32'h0000_0000);
        par_write(ADDR_CC_OPTIONS, 32'h0000_0102);
        reg_check(ADDR_CC_OPTIONS, 32'h0000_0000);
        par_write(ADDR_CC_OPTIONS, 32'h0000_0101);
        reg_check(ADDR_CC_OPTIONS, 32'h0000_0101);
        par_write(ADDR_CC_OPTIONS, 32'h0000_1000);
        reg_check(ADDR_CC_OPTIONS, 32'h0000_0101);
        par_write(16'h012c, 32'h0000_1234);
        reg_check(16'h012c, 32'h0000_0000);
        // tracking distance, off then on, then both clamp limits
        par_write(ADDR_TRACK_TIME, 32'd1500);
        MOTOR_SPEED = 16'd10;
        cyc(3);
        check32(TRACK_DIST, 32'h0000_0000, "tracking disabled");
        TRACK_ENABLE = 1'b1;
        cyc(3);
        check32(TRACK_DIST, 32'd15000, "tracking enabled");
        par_write(ADDR_TRACK_TIME, 32'h0000_fa24);
        cyc(1);
        check32(TRACK_DIST, 32'hffff_c568, "negative extra time");
        par_write(ADDR_TRACK_TIME, 32'h0000_7530);
        reg_check(ADDR_TRACK_TIME, 32'h0000_4e20);
        check32(TRACK_DIST, 32'd200000, "clamped extra time");
        par_write(ADDR_TRACK_TIME, 32'h0000_8ad0);
        reg_check(ADDR_TRACK_TIME, 32'hffff_b1e0);
        // cam phase at a steady ten pulses per window
        master_period = 8'd5;
        cyc(3 * WIN);
        check32({16'h0000, MASTER_RATE}, 32'd10, "master rate");
        for (int k = 0; k < 8; k++) begin
            par_write(ADDR_CAM_PHASE_TIME, {16'h0000, cam_time[k]});
            par_write(ADDR_CAM_MIN_RATE, {16'h0000, cam_min[k]});
            CAM_RUN = cam_run[k];
            cyc(3);
            check32(CAM_PHASE, cam_exp[k], "cam phase");
        end
        // masking: clamp, back-to-back events, pulse count boundary, then switched off mid-mask
        par_write(ADDR_CAPTURE_MASK, 32'h0600_0000);
        reg_check(ADDR_CAPTURE_MASK, MASK_MAX);
        par_write(ADDR_CAPTURE_MASK, 32'd2);
        CAP_EVENT = 1'b1;
        @(negedge CLK);
        check1(CAP_ACCEPT, 1'b1, "first capture");
        capture(1'b0, 1'b1, "event right after capture");
        axis_u.send_cap(1);
        capture(1'b0, 1'b1, "one pulse into mask");
        axis_u.send_cap(1);
        cyc(1);
        capture(1'b1, 1'b0, "mask range passed");
        par_write(ADDR_CAPTURE_MASK, 32'd0);
        CAP_EVENT = 1'b1;
        @(negedge CLK);
        check1(CAP_ACCEPT, 1'b1, "unmasked capture");
        capture(1'b1, 1'b0, "back-to-back unmasked");
        // repeating capture and one-shot offset
        CAPTURE_ARRAY_START = 16'h0040;
        par_write(ADDR_CC_OPTIONS, 32'h0000_0001);
        strobe_last(1'b1);
        check32({16'h0000, CAP_ARRAY_BASE}, 32'h0000_0040, "array base");
        check1(CAP_RESTART, 1'b0, "restart is one pulse");
        par_write(ADDR_CC_OPTIONS, 32'h0000_0100);
        strobe_last(1'b0);
        par_write(ADDR_ONE_SHOT_OFFSET, 32'h0000_04d2);
        check32(CMP_OFFSET, 32'h0000_04d2, "offset written");
        compare_once(32'h0000_0000);
        reg_check(ADDR_ONE_SHOT_OFFSET, 32'h0000_0000);
        par_write(ADDR_CC_OPTIONS, 32'h0000_0000);
        par_write(ADDR_ONE_SHOT_OFFSET, 32'h0000_04d2);
        compare_once(32'h0000_04d2);
        wrap_up();
    end

    // whole run is near 300 cycles; a hang is cut well beyond that
    initial begin
        repeat (20000) @(posedge CLK);
        err_count++;
        $display("Error at %0t: watchdog expired", $time);
        wrap_up();
    end
endmodule

`default_nettype wire

// [hw/cc_comp.sv]
// capture/compare auxiliary settings and compensation logic
// assumes capture and compare engines outside report their events as
// one-cycle strobes and take the offsets and restart from these outputs
`default_nettype none

// Functional notes
// - tracking-error time compensation is applied only while the tracking enable input is 1.
// - the extra tracking distance is the signed extra time, clamped to +/-20.000 ms, times motor speed.
// - while the cam runs, phase shift is cam phase time times (master rate in Kpps minus minimum rate).
// - cam phase compensation happens only when cam phase time is above zero.
// - cam phase compensation happens only when the measured master rate exceeds the minimum rate.
// - with capture option bit 0 set, capture restarts after the last point at the array start address.
// - with compare option bit 8 set, the one-shot offset is cleared after one compare, else it stays.
// - after each captured point, capture events within the masking range of axis pulses are ignored.
// - a masking range of zero disables masking entirely.
module cc_comp
    import cc_comp_pkg::*;
#(
    parameter int RATE_WINDOW = RATE_WINDOW_CYCLES
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RST,
    // parameter port
    input wire logic PAR_WR,
    input wire logic PAR_RD,
    input wire logic [15:0] PAR_ADDR,
    input wire logic [31:0] PAR_WDATA,
    output logic [31:0] PAR_RDATA,
    output logic PAR_RVALID,
    // tracking compensation
    input wire logic TRACK_ENABLE,
    input wire logic [15:0] MOTOR_SPEED,
    output logic [31:0] TRACK_DIST,
    // electronic cam
    input wire logic CAM_RUN,
    input wire logic MASTER_PULSE,
    output logic [15:0] MASTER_RATE,
    output logic [31:0] CAM_PHASE,
    // capture
    input wire logic CAP_EVENT,
    input wire logic CAP_PULSE,
    input wire logic CAP_LAST,
    input wire logic [15:0] CAPTURE_ARRAY_START,
    output logic CAP_ACCEPT,
    output logic CAP_MASKED,
    output logic CAP_RESTART,
    output logic [15:0] CAP_ARRAY_BASE,
    // compare
    input wire logic CMP_DONE,
    output logic [31:0] CMP_OFFSET
);

    // ----------------------------------------
    // parameter registers
    // ----------------------------------------
    par_req_t req;
    logic signed [15:0] track_time_reg, track_time_next;
    logic signed [15:0] cam_phase_time_reg, cam_phase_time_next;
    logic [15:0] cc_options_reg, cc_options_next;
    logic [31:0] capture_mask_reg, capture_mask_next;
    logic signed [15:0] cam_min_rate_reg, cam_min_rate_next;
    logic [31:0] one_shot_offset_reg, one_shot_offset_next;
    logic [31:0] rdata_reg, rdata_next;
    logic rvalid_reg, rvalid_next;
    logic signed [15:0] wtime;

    assign req = '{wr: PAR_WR, rd: PAR_RD, addr: PAR_ADDR, wdata: PAR_WDATA};

    always_comb begin
        track_time_next = track_time_reg;
        cam_phase_time_next = cam_phase_time_reg;
        cc_options_next = cc_options_reg;
        capture_mask_next = capture_mask_reg;
        cam_min_rate_next = cam_min_rate_reg;
        one_shot_offset_next = one_shot_offset_reg;
        rdata_next = 32'h0;
        rvalid_next = req.rd;
        // out-of-range times are clamped, not rejected
        wtime = req.wdata[15:0];
        if (wtime > TIME_MAX) begin
            wtime = TIME_MAX;
        end else if (wtime < TIME_MIN) begin
            wtime = TIME_MIN;
        end
        // a completed compare clears first; a write in the same cycle wins
        if (CMP_DONE && cc_options_reg[OPT_CMP_ONE_SHOT_BIT]) begin
            one_shot_offset_next = 32'h0;
        end
        if (req.wr) begin
            case (req.addr)
                ADDR_TRACK_TIME: track_time_next = wtime;
                ADDR_CAM_PHASE_TIME: cam_phase_time_next = wtime;
                ADDR_CC_OPTIONS: begin
                    if ((req.wdata[15:0] & ~OPT_LEGAL_MASK) == 16'h0) begin
                        cc_options_next = req.wdata[15:0];
                    end
                end
                ADDR_CAPTURE_MASK: begin
                    capture_mask_next = (req.wdata > MASK_MAX) ? MASK_MAX : req.wdata;
                end
                ADDR_CAM_MIN_RATE: cam_min_rate_next = req.wdata[15:0];
                ADDR_ONE_SHOT_OFFSET: one_shot_offset_next = req.wdata;
                default: ;
            endcase
        end
        if (req.rd) begin
            case (req.addr)
                ADDR_TRACK_TIME: rdata_next = {{16{track_time_reg[15]}}, track_time_reg};
                ADDR_CAM_PHASE_TIME: rdata_next = {{16{cam_phase_time_reg[15]}}, cam_phase_time_reg};
                ADDR_CC_OPTIONS: rdata_next = {16'h0, cc_options_reg};
                ADDR_CAPTURE_MASK: rdata_next = capture_mask_reg;
                ADDR_CAM_MIN_RATE: rdata_next = {{16{cam_min_rate_reg[15]}}, cam_min_rate_reg};
                ADDR_ONE_SHOT_OFFSET: rdata_next = one_shot_offset_reg;
                default: rdata_next = 32'h0;
            endcase
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            track_time_reg <= RST_TRACK_TIME;
            cam_phase_time_reg <= RST_CAM_PHASE_TIME;
            cc_options_reg <= RST_CC_OPTIONS;
            capture_mask_reg <= RST_CAPTURE_MASK;
            cam_min_rate_reg <= RST_CAM_MIN_RATE;
            one_shot_offset_reg <= RST_ONE_SHOT_OFFSET;
            rdata_reg <= 32'h0;
            rvalid_reg <= 1'b0;
        end else begin
            track_time_reg <= track_time_next;
            cam_phase_time_reg <= cam_phase_time_next;
            cc_options_reg <= cc_options_next;
            capture_mask_reg <= capture_mask_next;
            cam_min_rate_reg <= cam_min_rate_next;
            one_shot_offset_reg <= one_shot_offset_next;
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
        end
    end

    // ----------------------------------------
    // tracking and cam compensation
    // ----------------------------------------
    logic [15:0] master_rate;
    logic [31:0] track_dist_reg, track_dist_next;
    logic [31:0] cam_phase_reg, cam_phase_next;
    logic signed [17:0] rate_diff;
    logic signed [33:0] cam_prod;
    logic cam_on;

    pulse_rate_meter #(
        .WINDOW_CYCLES(RATE_WINDOW),
        .RATE_W(16)
    ) u_rate (
        .clk(CLK),
        .rst(RST),
        .pulse(MASTER_PULSE),
        .rate(master_rate)
    );

    // products are in microsecond units; the consumer scales by 1/1000
    always_comb begin
        // one bit of headroom: a saturated rate minus a negative minimum must not wrap
        rate_diff = 18'($signed({1'b0, master_rate})) - 18'(cam_min_rate_reg);
        cam_prod = 34'(cam_phase_time_reg) * 34'(rate_diff);
        cam_on = CAM_RUN && (cam_phase_time_reg > 16'sh0000)
            && (rate_diff > 18'sh0);
        cam_phase_next = cam_on ? cam_prod[31:0] : 32'h0;
        track_dist_next = 32'h0;
        if (TRACK_ENABLE) begin
            track_dist_next = 32'(track_time_reg) * 32'($signed(MOTOR_SPEED));
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            track_dist_reg <= 32'h0;
            cam_phase_reg <= 32'h0;
        end else begin
            track_dist_reg <= track_dist_next;
            cam_phase_reg <= cam_phase_next;
        end
    end

    // ----------------------------------------
    // capture masking and repeat
    // ----------------------------------------
    mask_state_t mask_state_reg, mask_state_next;
    logic [MASK_W-1:0] mask_cnt_reg, mask_cnt_next;
    logic accept_reg, accept_next;
    logic masked_reg, masked_next;
    logic restart_reg, restart_next;
    logic [15:0] base_reg, base_next;

    always_comb begin
        mask_state_next = mask_state_reg;
        mask_cnt_next = mask_cnt_reg;
        accept_next = 1'b0;
        masked_next = 1'b0;
        restart_next = 1'b0;
        base_next = base_reg;
        case (mask_state_reg)
            MASK_IDLE: begin
                if (CAP_EVENT) begin
                    accept_next = 1'b1;
                    if (capture_mask_reg != 32'h0) begin
                        mask_state_next = MASK_ACTIVE;
                        mask_cnt_next = capture_mask_reg[MASK_W-1:0];
                    end
                end
            end
            MASK_ACTIVE: begin
                // a range cleared mid-window ends masking at once
                if (capture_mask_reg == 32'h0) begin
                    mask_state_next = MASK_IDLE;
                    accept_next = CAP_EVENT;
                end else begin
                    masked_next = CAP_EVENT;
                    if (CAP_PULSE) begin
                        mask_cnt_next = mask_cnt_reg - {{(MASK_W-1){1'b0}}, 1'b1};
                        if (mask_cnt_reg == {{(MASK_W-1){1'b0}}, 1'b1}) begin
                            mask_state_next = MASK_IDLE;
                        end
                    end
                end
            end
            default: mask_state_next = MASK_IDLE;
        endcase
        // the array start is sampled here so a restart reuses it
        if (CAP_LAST && cc_options_reg[OPT_CAP_REPEAT_BIT]) begin
            restart_next = 1'b1;
            base_next = CAPTURE_ARRAY_START;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            mask_state_reg <= MASK_IDLE;
            mask_cnt_reg <= '0;
            accept_reg <= 1'b0;
            masked_reg <= 1'b0;
            restart_reg <= 1'b0;
            base_reg <= 16'h0;
        end else begin
            mask_state_reg <= mask_state_next;
            mask_cnt_reg <= mask_cnt_next;
            accept_reg <= accept_next;
            masked_reg <= masked_next;
            restart_reg <= restart_next;
            base_reg <= base_next;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign PAR_RDATA = rdata_reg;
    assign PAR_RVALID = rvalid_reg;
    assign TRACK_DIST = track_dist_reg;
    assign CAM_PHASE = cam_phase_reg;
    assign MASTER_RATE = master_rate;
    assign CAP_ACCEPT = accept_reg;
    assign CAP_MASKED = masked_reg;
    assign CAP_RESTART = restart_reg;
    assign CAP_ARRAY_BASE = base_reg;
    assign CMP_OFFSET = one_shot_offset_reg;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);

    sequence s_capture_taken;
        mask_state_reg == MASK_IDLE && CAP_EVENT && capture_mask_reg != 32'h0;
    endsequence

    sequence s_masked_event;
        mask_state_reg == MASK_ACTIVE && CAP_EVENT && capture_mask_reg != 32'h0;
    endsequence

    track_off_a: assert property (!TRACK_ENABLE |=> TRACK_DIST == 32'h0)
        else $error("tracking distance nonzero while disabled");
    track_limit_a: assert property (track_time_reg <= TIME_MAX && track_time_reg >= TIME_MIN)
        else $error("tracking time outside limit");
    cam_nonpos_a: assert property (cam_phase_time_reg <= 16'sh0000 |=> CAM_PHASE == 32'h0)
        else $error("cam phase applied with nonpositive time");
    cam_slow_a: assert property ($signed({1'b0, master_rate}) <= 17'(cam_min_rate_reg) |=> CAM_PHASE == 32'h0)
        else $error("cam phase applied below minimum rate");
    cam_stop_a: assert property (!CAM_RUN |=> CAM_PHASE == 32'h0)
        else $error("cam phase applied while cam stopped");
    opt_legal_a: assert property ((cc_options_reg & ~OPT_LEGAL_MASK) == 16'h0)
        else $error("options word holds reserved bits");
    repeat_restart_a: assert property (CAP_LAST && cc_options_reg[0] |=> CAP_RESTART
        && CAP_ARRAY_BASE == $past(CAPTURE_ARRAY_START))
        else $error("capture did not restart after last point");
    no_restart_a: assert property (!CAP_LAST |=> !CAP_RESTART)
        else $error("restart without last point");
    one_shot_a: assert property (CMP_DONE && cc_options_reg[8] && !PAR_WR |=> CMP_OFFSET == 32'h0)
        else $error("one-shot offset not cleared");
    offset_keep_a: assert property (!cc_options_reg[8] && !PAR_WR |=> $stable(CMP_OFFSET))
        else $error("offset changed without write");
    mask_block_a: assert property (s_masked_event |=> CAP_MASKED && !CAP_ACCEPT)
        else $error("event inside masking range accepted");
    mask_enter_a: assert property (s_capture_taken |=> mask_state_reg == MASK_ACTIVE
        && mask_cnt_reg == $past(capture_mask_reg[MASK_W-1:0]))
        else $error("masking window not loaded");
    mask_zero_a: assert property (capture_mask_reg == 32'h0 && mask_state_reg == MASK_IDLE
        |=> mask_state_reg == MASK_IDLE)
        else $error("masking active with zero range");
    mask_off_a: assert property (capture_mask_reg == 32'h0 && CAP_EVENT |=> CAP_ACCEPT && !CAP_MASKED)
        else $error("event masked with zero range");

endmodule

`default_nettype wire

// [hw/cc_comp_pkg.sv]
// package: register map, field layout, limits and timing of the
// capture/compare compensation block
// assumes a single 50 MHz clock and a word-addressed parameter port
`default_nettype none

package cc_comp_pkg;

    // ----------------------------------------
    // clock and timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 20;
    localparam int RATE_WINDOW_NS = 1000000;
    localparam int RATE_WINDOW_CYCLES = RATE_WINDOW_NS / CLK_PERIOD_NS;

    // ----------------------------------------
    // parameter addresses
    // ----------------------------------------
    localparam logic [15:0] ADDR_TRACK_TIME = 16'h0122;
    localparam logic [15:0] ADDR_CAM_PHASE_TIME = 16'h0124;
    localparam logic [15:0] ADDR_CC_OPTIONS = 16'h0126;
    localparam logic [15:0] ADDR_CAPTURE_MASK = 16'h0128;
    localparam logic [15:0] ADDR_CAM_MIN_RATE = 16'h012a;
    localparam logic [15:0] ADDR_ONE_SHOT_OFFSET = 16'h0130;

    // ----------------------------------------
    // reset values and limits
    // ----------------------------------------
    localparam logic [15:0] RST_TRACK_TIME = 16'h0000;
    localparam logic [15:0] RST_CAM_PHASE_TIME = 16'h0000;
    localparam logic [15:0] RST_CC_OPTIONS = 16'h0000;
    localparam logic [31:0] RST_CAPTURE_MASK = 32'h0000_0000;
    localparam logic [15:0] RST_CAM_MIN_RATE = 16'h0000;
    localparam logic [31:0] RST_ONE_SHOT_OFFSET = 32'h0000_0000;
    // time settings in microseconds, i.e. +/-20.000 ms
    localparam int TIME_LIMIT_US = 20000;
    localparam logic signed [15:0] TIME_MAX = 16'sh4e20;
    localparam logic signed [15:0] TIME_MIN = -16'sh4e20;
    // masking range in capture-axis pulses, 100000000
    localparam logic [31:0] MASK_MAX = 32'h05f5_e100;
    localparam int MASK_W = 27;
    // options word: only these bits may be set
    localparam logic [15:0] OPT_LEGAL_MASK = 16'h0101;
    localparam int OPT_CAP_REPEAT_BIT = 0;
    localparam int OPT_CMP_ONE_SHOT_BIT = 8;

    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [31:0] wdata;
    } par_req_t;

    typedef enum logic [0:0] {
        MASK_IDLE = 1'b0,
        MASK_ACTIVE = 1'b1
    } mask_state_t;

endpackage

`default_nettype wire

// [hw/pulse_rate_meter.sv]
// pulse rate meter: counts strobes over a fixed window and holds the
// result; with a 1 ms window the count reads directly in Kpps
// assumes the pulse input is a one-cycle strobe synchronous to clk
`default_nettype none

module pulse_rate_meter #(
    parameter int WINDOW_CYCLES = 50000,
    parameter int RATE_W = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic pulse,
    output logic [RATE_W-1:0] rate
);

    logic [31:0] win_reg, win_next;
    logic [RATE_W-1:0] cnt_reg, cnt_next;
    logic [RATE_W-1:0] rate_reg, rate_next;

    always_comb begin
        win_next = win_reg + 32'h1;
        cnt_next = cnt_reg;
        rate_next = rate_reg;
        // saturate rather than wrap so an overrun never reads as slow
        if (pulse && cnt_reg != {RATE_W{1'b1}}) begin
            cnt_next = cnt_reg + {{(RATE_W-1){1'b0}}, 1'b1};
        end
        if (win_reg == 32'(WINDOW_CYCLES - 1)) begin
            win_next = 32'h0;
            rate_next = cnt_next;
            cnt_next = '0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            win_reg <= 32'h0;
            cnt_reg <= '0;
            rate_reg <= '0;
        end else begin
            win_reg <= win_next;
            cnt_reg <= cnt_next;
            rate_reg <= rate_next;
        end
    end

    assign rate = rate_reg;

endmodule

`default_nettype wire
